// File: pkg/psm_pkg.sv
// package: constants and types for the port-share pin multiplexer
package psm_pkg;
  // ****************************************
  // pin function codes
  // ****************************************
  typedef enum logic [3:0] {
    PSM_FN_GPIO,
    PSM_FN_LED_SEG,
    PSM_FN_LCD_SEG,
    PSM_FN_SER_RX,
    PSM_FN_SER_TX,
    PSM_FN_FAULT,
    PSM_FN_LED_COM,
    PSM_FN_LCD_COM,
    PSM_FN_ADC_REF,
    PSM_FN_ANALOG,
    PSM_FN_GRP_INT,
    PSM_FN_CODE_OPT,
    PSM_FN_BUZZER,
    PSM_FN_TMR_IN
  } psm_fn_t;

  // ****************************************
  // positions and values
  // ****************************************
  localparam int PSM_RX_PIN      = 0;
  localparam int PSM_TX_PIN      = 1;
  localparam int PSM_FAULT_PIN   = 5;
  localparam int PSM_REF_PIN     = 4;
  localparam int PSM_BUZ_PIN     = 3;
  localparam int PSM_CODE_PINS   = 3;
  localparam logic [1:0] PSM_TMR_EXT_CLK = 2'h1;
  localparam logic [7:0] PSM_RST_BYTE    = 8'h00;
  localparam logic [3:0] PSM_RST_NIB     = 4'h0;
endpackage : psm_pkg

// File: verification/psm_pad_model.sv
// pad-side partner: resolves each pad from design drive, external drive and pull-up
`timescale 1ns/10ps
`default_nettype none
module psm_pad_model (
  input  wire logic        CLK,
  input  wire logic [39:0] pin_o,
  input  wire logic [39:0] pin_oe_n,
  input  wire logic [39:0] pin_pu,
  input  wire logic [39:0] ext_en,
  input  wire logic [39:0] ext_val,
  output var  logic [39:0] pin_in
);
  // ****************************************
  // pad resolution
  // ****************************************
  logic [39:0] float_q = 40'h0;
  // a floating pad must never look like a stable level
  always_ff @(posedge CLK) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_o[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pu[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule : psm_pad_model
`default_nettype wire

// File: verification/tb_psm_pin_mux.sv
// self-checking bench for the port-share pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb_psm_pin_mux;
  import psm_pkg::*;
  typedef struct {int due; logic [39:0] own, o, om, oe, em, sd, sm;} psm_note_t;
  logic        clk = 1'b0, rst_n, dts, duty, rxe, txw, txdn, txdat, pwm_fault_input, rfc, pwr, grpe, buzzer_output, buzd;
  logic        run, rx_in, flt_in, tmr_in, tx_act;
  logic [7:0]  s1, s2, s3, segl, segh, com;
  logic [3:0]  adce, grps, gi;
  logic [2:0]  ch, code;
  logic [1:0]  src;
  logic [39:0] pout, pdir, ext_en, ext_val, pin_in, po, poe, ppu, pown;
  logic [127:0] rr;
  int          cyc = 0, fail_count = 0, checks = 0;
  int          seed;
  psm_note_t   q[$];

  psm_pin_mux dut (.CLK(clk), .RST_N(rst_n), .DISPLAY_TYPE_SELECT(dts), .DUTY_SELECT(duty),
    .PORT1_SEGMENT_SELECTS(s1), .PORT2_SEGMENT_SELECTS(s2), .PORT3_SELECTS(s3),
    .SERIAL_RX_ENABLE(rxe), .SERIAL_TX_BUFFER_WRITE(txw), .SERIAL_TX_DONE(txdn),
    .SERIAL_TX_DATA(txdat), .FAULT_INPUT_ENABLE(pwm_fault_input), .ADC_REFERENCE_CONTROL(rfc),
    .ADC_POWER_ON(pwr), .ADC_LOW_PIN_ENABLES(adce), .ADC_CHANNEL_SELECT(ch),
    .GROUP_INTERRUPT_ENABLE(grpe), .GROUP_INTERRUPT_PIN_SELECTS(grps),
    .CODE_OPTION_SELECTS(code), .BUZZER_ENABLE(buzzer_output), .BUZZER_DATA(buzd),
    .SECOND_TIMER_RUN(run), .SECOND_TIMER_CLOCK_SOURCE(src), .SEG_DATA_LOW(segl),
    .SEG_DATA_HIGH(segh), .COM_DATA(com), .PORT_OUT(pout), .PORT_DIR_OUT(pdir),
    .PIN_IN(pin_in), .PIN_O(po), .PIN_OE_N(poe), .PIN_PU(ppu), .PIN_OWNED(pown),
    .SERIAL_RX_IN(rx_in), .PWM_FAULT_INPUT(flt_in), .GROUPED_EXT_INTERRUPTS(gi),
    .TIMER_EXT_INPUT(tmr_in));
  psm_pad_model pads (.CLK(clk), .pin_o(po), .pin_oe_n(poe), .pin_pu(ppu), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    // non-blocking so every reader at this edge sees the same count
    cyc <= cyc + 1;
    // runs are about 2130 cycles, so this only trips on a hang
    if (cyc == 4000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic cmp(input string nm, input logic [39:0] e, g, m);
    checks++;
    if (((e ^ g) & m) !== 40'h0) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask : cmp

  // ****************************************
  // reference model: note what the pins must show
  // ****************************************
  task automatic predict(input int d);
    psm_note_t n;
    logic [39:0] inp, drv, dv;
    logic [7:0]  m2;
    logic [3:0]  an, g;
    logic        tm;
    for (int i = 0; i < 4; i++) begin
      an[i] = adce[i] & pwr & (ch == 3'(i));
      g[i] = grpe & grps[i] & ~pdir[24+i] & ~an[i];
    end
    tm = run & (src == PSM_TMR_EXT_CLK) & ~buzzer_output;
    // receive, transmit and fault pins keep their segment drive off
    m2 = {2'b0, pwm_fault_input, 3'b0, tx_act, rxe};
    n.due = cyc + d;
    n.own = {4'h0, buzzer_output | tm, code, 3'h0, rfc, an | g, s3 & {8{duty}}, s2 & {8{~dts}}, s1};
    n.own[8] |= rxe;
    n.own[9] |= tx_act;
    n.own[13] |= pwm_fault_input;
    inp = {4'h0, tm, code, 3'h0, rfc, an | g, 10'h0, pwm_fault_input, 4'h0, rxe, 8'h0};
    drv = {4'h0, buzzer_output, 11'h0, s3 & {8{duty}}, (s2 & {8{~dts}} & ~m2) | {6'h0, tx_act, 1'b0}, s1};
    dv = {4'h0, buzd, 11'h0, com, segh[7:2], tx_act ? txdat : segh[1], segh[0], segl};
    n.o = (pout & ~drv) | (dv & drv);
    n.om = ~n.own | drv;
    n.oe = (~pdir | inp) & ~drv;
    n.em = ~n.own | inp | drv;
    n.sd = {31'h0, tm, rxe, tm ? ext_val[35] : 1'b1, pwm_fault_input ? ext_val[13] : 1'b1,
            rxe ? ext_val[8] : 1'b1, (ext_val[27:24] & g) | ~g};
    n.sm = 40'h1ff;
    q.push_back(n);
  endtask : predict

  always @(negedge clk) begin : mon
    psm_note_t n;
    if (q.size() > 0 && cyc >= q[0].due) begin
      n = q.pop_front();
      cmp("owned", n.own, pown, '1);
      cmp("pin_out", n.o, po, n.om);
      cmp("pin_oe_n", n.oe, poe, n.em);
      cmp("side", n.sd, {31'h0, ppu[35], ppu[8], tmr_in, flt_in, rx_in, gi}, n.sm);
      cmp("pin_pu", {4'h0, n.sd[8], 26'h0, n.sd[7], 8'h0}, ppu, '1);
    end
  end

  task automatic do_reset();
    rst_n <= 1'b0;
    tx_act = 1'b0;
    repeat (3) @(posedge clk);
    q.push_back('{cyc + 3, 40'h0, 40'h0, '1, '1, '1, 40'h7f, 40'h1ff});
    repeat (7) @(posedge clk);
  endtask : do_reset

  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // ****************************************
  // random walk through 300 random enable combinations
  // ****************************************
  initial begin : main
    logic w, d;
    seed = 32'h7c66860b;
    {dts, duty, rxe, txw, txdn, txdat, pwm_fault_input, rfc, pwr, grpe, buzzer_output, buzd, run} = '0;
    {s1, s2, s3, segl, segh, com, adce, grps, ch, src} = '0;
    {pout, pdir, ext_en, ext_val} = '0;
    code = 3'h5;
    do_reset();
    for (int k = 0; k < 300; k++) begin
      if (k == 150) begin
        do_reset();
        code <= 3'h2;
      end
      rst_n <= 1'b1;
      rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {dts, duty, rxe, txdat, pwm_fault_input, rfc, pwr, grpe, buzzer_output, buzd, run, adce, grps, ch, src} <= rr[23:0];
      {s1, s2, s3, segl, segh, com} <= rr[74:27];
      {w, d} = rr[76:75];
      txw <= w;
      txdn <= d;
      if (w) tx_act = 1'b1;
      else if (d) tx_act = 1'b0;
      rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
      pout <= rr[39:0];
      pdir <= rr[79:40];
      ext_val <= rr[119:80];
      // receive, fault, group interrupt and timer pads are always driven from outside so levels are known
      ext_en <= {rr[127:120], rr[31:0]} | 40'h80f002100;
      @(posedge clk);
      txw <= 1'b0;
      txdn <= 1'b0;
      predict(6);
      repeat (6) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    end_of_test();
  end
endmodule : tb_psm_pin_mux
`default_nettype wire

// File: verilog/psm_pin_cell.sv
// one pin: merges a shared function drive with the port data path
`timescale 1ns/10ps
`default_nettype none
module psm_pin_cell
  import psm_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic own,
  input  wire logic fn_drive,
  input  wire logic fn_oe_n,
  input  wire logic fn_pullup,
  input  wire logic port_out,
  input  wire logic port_dir_out,
  output var  logic pin_o,
  output var  logic pin_oe_n,
  output var  logic pin_pu
);
  logic o_d, oe_n_d, pu_d;
  logic o_q, oe_n_q, pu_q;

  always_comb begin
    // port register writes stay latched but do not reach a pin a function owns
    if (own) begin
      o_d    = fn_drive;
      oe_n_d = fn_oe_n;
      pu_d   = fn_pullup;
    end else begin
      o_d    = port_out;
      oe_n_d = ~port_dir_out;
      pu_d   = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      o_q    <= 1'b0;
      oe_n_q <= 1'b1;
      pu_q   <= 1'b0;
    end else begin
      o_q    <= o_d;
      oe_n_q <= oe_n_d;
      pu_q   <= pu_d;
    end
  end

  assign pin_o    = o_q;
  assign pin_oe_n = oe_n_q;
  assign pin_pu   = pu_q;
endmodule : psm_pin_cell
`default_nettype wire

// File: verilog/psm_pin_mux.sv
// top: priority pin-function multiplexer for ports 1 to 5
// Contract
// - port1 pin is led segment when led display and its select set
// - port1 pin is lcd segment when display is lcd and select set
// - with no function enabled, pin is ordinary bidirectional port
// - receive enable claims port2 pin0 as serial input with pull-up
// - transmit buffer write claims port2 pin1 as serial output
// - port2 pin is lcd segment 9-16 when lcd and its select set
// - fault enable claims port2 pin5 as fault input over segment
// - port3 pins4-7 led commons when select, led type and duty set
// - port3 pins4-7 lcd commons when select, lcd type and duty set
// - port3 pins0-3 led commons first, else lcd commons when lcd type; the code also needs select and duty set
// - reference control makes port4 pin4 the adc reference input
// - port4 pins0-3 analog when pin enable, power and channel match
// - port4 pins0-3 group interrupts when enabled, selected, input
// - port5 pins0-2 crystal and reset only by fixed code option
// - buzzer enable makes port5 pin3 buzzer over timer and port
// - port5 pin3 timer input with pull-up when run and source 01
// - higher priority function blocks lower ones from the pin
// - port accesses touch only data register while function owns pin
`timescale 1ns/10ps
`default_nettype none
module psm_pin_mux
  import psm_pkg::*;
#(
  parameter int NPIN = 8
)(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             DISPLAY_TYPE_SELECT,
  input  wire logic             DUTY_SELECT,
  input  wire logic [NPIN-1:0]  PORT1_SEGMENT_SELECTS,
  input  wire logic [NPIN-1:0]  PORT2_SEGMENT_SELECTS,
  input  wire logic [NPIN-1:0]  PORT3_SELECTS,
  input  wire logic             SERIAL_RX_ENABLE,
  input  wire logic             SERIAL_TX_BUFFER_WRITE,
  input  wire logic             SERIAL_TX_DONE,
  input  wire logic             SERIAL_TX_DATA,
  input  wire logic             FAULT_INPUT_ENABLE,
  input  wire logic             ADC_REFERENCE_CONTROL,
  input  wire logic             ADC_POWER_ON,
  input  wire logic [3:0]       ADC_LOW_PIN_ENABLES,
  input  wire logic [2:0]       ADC_CHANNEL_SELECT,
  input  wire logic             GROUP_INTERRUPT_ENABLE,
  input  wire logic [3:0]       GROUP_INTERRUPT_PIN_SELECTS,
  input  wire logic [2:0]       CODE_OPTION_SELECTS,
  input  wire logic             BUZZER_ENABLE,
  input  wire logic             BUZZER_DATA,
  input  wire logic             SECOND_TIMER_RUN,
  input  wire logic [1:0]       SECOND_TIMER_CLOCK_SOURCE,
  input  wire logic [NPIN-1:0]  SEG_DATA_LOW,
  input  wire logic [NPIN-1:0]  SEG_DATA_HIGH,
  input  wire logic [NPIN-1:0]  COM_DATA,
  input  wire logic [5*NPIN-1:0] PORT_OUT,
  input  wire logic [5*NPIN-1:0] PORT_DIR_OUT,
  input  wire logic [5*NPIN-1:0] PIN_IN,
  output var  logic [5*NPIN-1:0] PIN_O,
  output var  logic [5*NPIN-1:0] PIN_OE_N,
  output var  logic [5*NPIN-1:0] PIN_PU,
  output var  logic [5*NPIN-1:0] PIN_OWNED,
  output var  logic             SERIAL_RX_IN,
  output var  logic             PWM_FAULT_INPUT,
  output var  logic [3:0]       GROUPED_EXT_INTERRUPTS,
  output var  logic             TIMER_EXT_INPUT
);
  // ****************************************
  // pin input synchronisers
  // ****************************************
  logic [5*NPIN-1:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge CLK) begin
    pin_s1_q <= PIN_IN;
    pin_s2_q <= pin_s1_q;
  end

  // ****************************************
  // ownership decode
  // ****************************************
  psm_fn_t           fn_d [5*NPIN];
  psm_fn_t           fn_q [5*NPIN];
  logic              tx_hold_q, tx_hold_d;
  logic [5*NPIN-1:0] drv, oen, pu, own;
  logic              led, lcd;

  assign led = DISPLAY_TYPE_SELECT;
  assign lcd = ~DISPLAY_TYPE_SELECT;

  // transmit owns the pin from buffer write until the frame ends
  always_comb begin
    tx_hold_d = tx_hold_q;
    if (SERIAL_TX_DONE) tx_hold_d = 1'b0;
    if (SERIAL_TX_BUFFER_WRITE) tx_hold_d = 1'b1;
  end

  always_comb begin
    for (int i = 0; i < 5*NPIN; i++) fn_d[i] = PSM_FN_GPIO;
    // each if/else chain lists functions highest priority first
    for (int i = 0; i < NPIN; i++) begin
      if (led && PORT1_SEGMENT_SELECTS[i]) fn_d[i] = PSM_FN_LED_SEG;
      else if (lcd && PORT1_SEGMENT_SELECTS[i]) fn_d[i] = PSM_FN_LCD_SEG;
      if (i == PSM_RX_PIN && SERIAL_RX_ENABLE) fn_d[NPIN+i] = PSM_FN_SER_RX;
      else if (i == PSM_TX_PIN && (tx_hold_q || SERIAL_TX_BUFFER_WRITE))
        fn_d[NPIN+i] = PSM_FN_SER_TX;
      else if (i == PSM_FAULT_PIN && FAULT_INPUT_ENABLE) fn_d[NPIN+i] = PSM_FN_FAULT;
      else if (lcd && PORT2_SEGMENT_SELECTS[i]) fn_d[NPIN+i] = PSM_FN_LCD_SEG;
      if (PORT3_SELECTS[i] && DUTY_SELECT && led) fn_d[2*NPIN+i] = PSM_FN_LED_COM;
      else if (PORT3_SELECTS[i] && DUTY_SELECT && lcd)
        fn_d[2*NPIN+i] = PSM_FN_LCD_COM;
    end
    for (int i = 0; i < 4; i++) begin
      if (ADC_LOW_PIN_ENABLES[i] && ADC_POWER_ON && ADC_CHANNEL_SELECT == 3'(i))
        fn_d[3*NPIN+i] = PSM_FN_ANALOG;
      else if (GROUP_INTERRUPT_ENABLE && GROUP_INTERRUPT_PIN_SELECTS[i]
               && !PORT_DIR_OUT[3*NPIN+i])
        fn_d[3*NPIN+i] = PSM_FN_GRP_INT;
    end
    if (ADC_REFERENCE_CONTROL) fn_d[3*NPIN+PSM_REF_PIN] = PSM_FN_ADC_REF;
    // crystal and reset pins follow only the fixed code option
    for (int i = 0; i < PSM_CODE_PINS; i++)
      if (CODE_OPTION_SELECTS[i]) fn_d[4*NPIN+i] = PSM_FN_CODE_OPT;
    if (BUZZER_ENABLE) fn_d[4*NPIN+PSM_BUZ_PIN] = PSM_FN_BUZZER;
    else if (SECOND_TIMER_RUN && SECOND_TIMER_CLOCK_SOURCE == PSM_TMR_EXT_CLK)
      fn_d[4*NPIN+PSM_BUZ_PIN] = PSM_FN_TMR_IN;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_hold_q <= 1'b0;
      for (int i = 0; i < 5*NPIN; i++) fn_q[i] <= PSM_FN_GPIO;
    end else begin
      tx_hold_q <= tx_hold_d;
      for (int i = 0; i < 5*NPIN; i++) fn_q[i] <= fn_d[i];
    end
  end

  // ****************************************
  // function drive per pin
  // ****************************************
  always_comb begin
    for (int i = 0; i < 5*NPIN; i++) begin
      own[i] = (fn_q[i] != PSM_FN_GPIO);
      drv[i] = 1'b0;
      oen[i] = 1'b1;
      pu[i]  = 1'b0;
      case (fn_q[i])
        PSM_FN_LED_SEG, PSM_FN_LCD_SEG: begin
          drv[i] = (i < NPIN) ? SEG_DATA_LOW[i % NPIN] : SEG_DATA_HIGH[i % NPIN];
          oen[i] = 1'b0;
        end
        PSM_FN_LED_COM, PSM_FN_LCD_COM: begin
          drv[i] = COM_DATA[i % NPIN];
          oen[i] = 1'b0;
        end
        PSM_FN_SER_TX: begin
          drv[i] = SERIAL_TX_DATA;
          oen[i] = 1'b0;
        end
        PSM_FN_BUZZER: begin
          drv[i] = BUZZER_DATA;
          oen[i] = 1'b0;
        end
        PSM_FN_SER_RX, PSM_FN_TMR_IN: pu[i] = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // port data path only reaches pins the functions release
  genvar g;
  generate
    for (g = 0; g < 5*NPIN; g++) begin : g_pin
      psm_pin_cell u_cell (
        .CLK          (CLK),
        .RST_N        (RST_N),
        .own          (own[g]),
        .fn_drive     (drv[g]),
        .fn_oe_n      (oen[g]),
        .fn_pullup    (pu[g]),
        .port_out     (PORT_OUT[g]),
        .port_dir_out (PORT_DIR_OUT[g]),
        .pin_o        (PIN_O[g]),
        .pin_oe_n     (PIN_OE_N[g]),
        .pin_pu       (PIN_PU[g])
      );
    end
  endgenerate

  // ****************************************
  // inputs routed to peripherals
  // ****************************************
  logic [5*NPIN-1:0] owned_q;
  logic              rx_q, flt_q, tmr_q;
  logic [3:0]        gint_q;
  logic              rx_d, flt_d, tmr_d;
  logic [3:0]        gint_d;

  always_comb begin
    // idle-high defaults so a released pin gives no false edge
    rx_d  = (fn_q[NPIN+PSM_RX_PIN] == PSM_FN_SER_RX) ? pin_s2_q[NPIN+PSM_RX_PIN] : 1'b1;
    flt_d = (fn_q[NPIN+PSM_FAULT_PIN] == PSM_FN_FAULT) ? pin_s2_q[NPIN+PSM_FAULT_PIN] : 1'b1;
    tmr_d = (fn_q[4*NPIN+PSM_BUZ_PIN] == PSM_FN_TMR_IN) ? pin_s2_q[4*NPIN+PSM_BUZ_PIN] : 1'b1;
    for (int i = 0; i < 4; i++)
      gint_d[i] = (fn_q[3*NPIN+i] == PSM_FN_GRP_INT) ? pin_s2_q[3*NPIN+i] : 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      owned_q <= '0;
      rx_q    <= 1'b1;
      flt_q   <= 1'b1;
      tmr_q   <= 1'b1;
      gint_q  <= 4'hf;
    end else begin
      owned_q <= own;
      rx_q    <= rx_d;
      flt_q   <= flt_d;
      tmr_q   <= tmr_d;
      gint_q  <= gint_d;
    end
  end

  assign PIN_OWNED              = owned_q;
  assign SERIAL_RX_IN           = rx_q;
  assign PWM_FAULT_INPUT        = flt_q;
  assign TIMER_EXT_INPUT        = tmr_q;
  assign GROUPED_EXT_INTERRUPTS = gint_q;

  // ****************************************
  // checks
  // ****************************************
  led_seg_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (led && PORT1_SEGMENT_SELECTS[0]) |=> fn_q[0] == PSM_FN_LED_SEG)
    else $error("led segment not taken");
  lcd_seg_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (lcd && PORT1_SEGMENT_SELECTS[7]) |=> fn_q[7] == PSM_FN_LCD_SEG)
    else $error("lcd segment not taken");
  gpio_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (fn_q[0] == PSM_FN_GPIO) |=> PIN_O[0] == $past(PORT_OUT[0]))
    else $error("released pin not port driven");
  rx_pullup_a: assert property (@(posedge CLK) disable iff (!RST_N)
    SERIAL_RX_ENABLE |=> ##1 PIN_PU[NPIN] && PIN_OE_N[NPIN])
    else $error("rx pin lacks pull-up");
  tx_claim_a: assert property (@(posedge CLK) disable iff (!RST_N)
    SERIAL_TX_BUFFER_WRITE |=> ##1 !PIN_OE_N[NPIN+1])
    else $error("tx pin not driven");
  lcd_hi_seg_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (lcd && PORT2_SEGMENT_SELECTS[2]) |=> fn_q[NPIN+2] == PSM_FN_LCD_SEG)
    else $error("upper lcd segment not taken");
  fault_prio_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (FAULT_INPUT_ENABLE && lcd) |=> fn_q[NPIN+5] == PSM_FN_FAULT)
    else $error("fault input lost priority");
  led_com_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (led && DUTY_SELECT && PORT3_SELECTS[4]) |=> fn_q[2*NPIN+4] == PSM_FN_LED_COM)
    else $error("led common not taken");
  ref_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ADC_REFERENCE_CONTROL |=> fn_q[3*NPIN+PSM_REF_PIN] == PSM_FN_ADC_REF)
    else $error("reference pin not taken");
  code_opt_a: assert property (@(posedge CLK) disable iff (!RST_N)
    CODE_OPTION_SELECTS[1] |=> fn_q[4*NPIN+1] == PSM_FN_CODE_OPT)
    else $error("code option pin not taken");
  buz_prio_a: assert property (@(posedge CLK) disable iff (!RST_N)
    BUZZER_ENABLE |=> fn_q[4*NPIN+3] == PSM_FN_BUZZER)
    else $error("buzzer lost priority");
  tmr_pullup_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (SECOND_TIMER_RUN && SECOND_TIMER_CLOCK_SOURCE == PSM_TMR_EXT_CLK && !BUZZER_ENABLE)
      |=> ##1 PIN_PU[4*NPIN+PSM_BUZ_PIN])
    else $error("timer pin lacks pull-up");
  seg_dir_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (fn_q[NPIN+2] == PSM_FN_LCD_SEG) |=> !PIN_OE_N[NPIN+2])
    else $error("port direction reached owned pin");
  analog_prio_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (fn_q[3*NPIN] == PSM_FN_GRP_INT) |-> !$past(ADC_LOW_PIN_ENABLES[0] && ADC_POWER_ON
      && ADC_CHANNEL_SELECT == 3'h0))
    else $error("interrupt over analog");
  release_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(BUZZER_ENABLE) && !SECOND_TIMER_RUN |=> fn_q[4*NPIN+3] == PSM_FN_GPIO)
    else $error("pin not released");
endmodule : psm_pin_mux
`default_nettype wire
